// File: rtl/prs_pkg.sv
// Purpose: shared constants for the protocol core reset and readiness sequencer
// Assumes: one 100 MHz fabric clock
// Notes:   counts are in fabric clock cycles
package prs_pkg;
    // --------------------------------------------------------------------
    // timing constants
    // --------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 10;     // fabric clock period
    localparam int unsigned CORE_RST_NS    = 200;    // internal core reset hold time
    localparam int unsigned CORE_RST_CYC   = (CORE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W          = 8;      // width of the hold counter
    localparam logic [7:0]  CORE_RST_CNT   = CORE_RST_CYC[7:0]; // cycles of internal reset
    localparam logic [7:0]  CNT_ZERO       = 8'h00;  // counter terminal value
    localparam logic [7:0]  CNT_ONE        = 8'h01;  // counter decrement step

    // --------------------------------------------------------------------
    // sequencer states
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {
        PRS_RESET = 2'b00,   // core held in reset
        PRS_WAIT  = 2'b01,   // waiting for pll lock and application ready
        PRS_RUN   = 2'b10    // running from the fabric clock
    } prs_state_t;
endpackage

// File: rtl/prs_sync.sv
// Purpose: two flip-flop synchroniser for one level
// Assumes: input is asynchronous to clk_i
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module prs_sync (
    input  wire logic core_clk_i,   // destination clock
    input  wire logic sys_rst_i,    // synchronous reset, active high
    input  wire logic rst_val_i,    // value taken under reset (tie to constant)
    input  wire logic async_i,      // asynchronous level
    output logic      sync_o        // synchronised level
);
    logic meta_q;   // first stage
    logic sync_q;   // second stage

    // --------------------------------------------------------------------
    // two stage capture
    // --------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= rst_val_i;
            sync_q <= rst_val_i;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// File: rtl/prs_core_reset.sv
// Purpose: reset and readiness sequencer between a protocol core and fabric logic
// Assumes: single fabric clock core_clk_i at 100 MHz; link events arrive as pins
// Notes:   all outputs are registered; the power-on reset is caught through a
//          synchroniser so the reset indication is fabric synchronous
`timescale 1ns/10ps
module prs_core_reset
    import prs_pkg::*;
(
    input  wire logic core_clk_i,          // fabric clock
    input  wire logic sys_rst_i,           // synchronous reset, active high
    input  wire logic por_n_i,             // power-on reset pin, active low, asynchronous
    input  wire logic slot_rst_n_i,        // slot reset pin, active low, asynchronous
    input  wire logic core_ready_i,        // application ready and clock stable
    input  wire logic pll_lock_raw_i,      // raw lock from the core pll, asynchronous
    input  wire logic hot_reset_i,         // link training in hot reset, asynchronous
    input  wire logic link_up_i,           // data link up, asynchronous
    input  wire logic pipe_sim_i,          // pipe simulation mode strap
    input  wire logic fast_init_i,         // accelerated initialization strap
    output logic      clk_inuse_o,         // core is running from fabric clock
    output logic      reset_status_o,      // core clock domain in reset, active high
    output logic      pll_locked_o,        // core pll locked
    output logic      fast_init_o,         // accelerated initialization active
    output logic      datapath_rst_o,      // datapath and control registers reset
    output logic      hot_rst_exit_n_o,    // one-cycle low pulse on hot reset exit
    output logic      link_up_exit_n_o     // one-cycle low pulse on link loss
);
    // --------------------------------------------------------------------
    // synchronised pin inputs
    // --------------------------------------------------------------------
    logic       por_n_s;        // power-on reset, synchronised
    logic       slot_n_s;       // slot reset, synchronised
    logic       lock_s;         // pll lock, synchronised
    logic       hot_s;          // hot reset state, synchronised
    logic       up_s;           // link up, synchronised
    logic       hot_prev_q;     // previous hot reset level
    logic       up_prev_q;      // previous link up level
    logic       pipe_q;         // pipe mode strap, sampled every clock
    logic       fast_q;         // fast init strap, sampled every clock
    prs_state_t state_q;        // sequencer state
    prs_state_t state_d;        // next sequencer state
    logic [7:0] cnt_q;          // internal reset hold counter
    logic       core_rst_q;     // internal core reset flag
    logic       lock_eff;       // effective lock incl. pipe mode
    logic       hot_exit;       // hot reset just left
    logic       link_lost;      // link just went down

    prs_sync u_sync_por (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .rst_val_i  (1'b0),
        .async_i    (por_n_i),
        .sync_o     (por_n_s)
    );
    prs_sync u_sync_slot (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .rst_val_i  (1'b0),
        .async_i    (slot_rst_n_i),
        .sync_o     (slot_n_s)
    );
    prs_sync u_sync_lock (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .rst_val_i  (1'b0),
        .async_i    (pll_lock_raw_i),
        .sync_o     (lock_s)
    );
    prs_sync u_sync_hot (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .rst_val_i  (1'b0),
        .async_i    (hot_reset_i),
        .sync_o     (hot_s)
    );
    prs_sync u_sync_up (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .rst_val_i  (1'b0),
        .async_i    (link_up_i),
        .sync_o     (up_s)
    );

    // --------------------------------------------------------------------
    // strap capture and edge history
    // --------------------------------------------------------------------
    // straps are sampled by clock, never loaded by the reset itself
    always_ff @(posedge core_clk_i) begin
        pipe_q <= pipe_sim_i;
        fast_q <= fast_init_i;
    end

    // previous levels for exit detection
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            hot_prev_q <= 1'b0;
            up_prev_q  <= 1'b0;
        end else begin
            hot_prev_q <= hot_s;
            up_prev_q  <= up_s;
        end
    end

    assign hot_exit  = hot_prev_q & ~hot_s;
    assign link_lost = up_prev_q & ~up_s;
    assign lock_eff  = lock_s | pipe_q;

    // --------------------------------------------------------------------
    // internal core reset flag
    // --------------------------------------------------------------------
    // power-up, hot reset and link loss reload the hold count
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_q      <= CORE_RST_CNT;
            core_rst_q <= 1'b1;
        end else if (!por_n_s || hot_s || hot_exit || link_lost) begin
            cnt_q      <= CORE_RST_CNT;
            core_rst_q <= 1'b1;
        end else if (cnt_q != CNT_ZERO) begin
            cnt_q      <= cnt_q - CNT_ONE;
            core_rst_q <= 1'b1;
        end else begin
            core_rst_q <= 1'b0;
        end
    end

    // --------------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------------
    // next state: leave reset, wait for lock and ready, then run
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PRS_RESET: begin
                if (!core_rst_q) begin
                    state_d = PRS_WAIT;
                end
            end
            PRS_WAIT: begin
                // ready from the application is only meaningful with lock
                if (core_rst_q) begin
                    state_d = PRS_RESET;
                end else if (lock_eff && core_ready_i) begin
                    state_d = PRS_RUN;
                end
            end
            PRS_RUN: begin
                if (core_rst_q) begin
                    state_d = PRS_RESET;
                end else if (!core_ready_i) begin
                    state_d = PRS_WAIT;
                end
            end
            default: begin
                state_d = PRS_RESET;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_q <= PRS_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // --------------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------------
    // clock-in-use follows the run state
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            clk_inuse_o <= 1'b0;
        end else begin
            clk_inuse_o <= (state_d == PRS_RUN);
        end
    end

    // reset indication: clears only with power-on released and flag clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reset_status_o <= 1'b1;
        end else begin
            reset_status_o <= ~por_n_s | core_rst_q;
        end
    end

    // slot reset and power-on reset both clear the datapath
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            datapath_rst_o <= 1'b1;
        end else begin
            datapath_rst_o <= ~slot_n_s | ~por_n_s;
        end
    end

    // lock and fast-init flags
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pll_locked_o <= 1'b0;
            fast_init_o  <= 1'b0;
        end else begin
            pll_locked_o <= lock_eff;
            fast_init_o  <= fast_q;
        end
    end

    // exit pulses, active low, one cycle each
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            hot_rst_exit_n_o <= 1'b1;
            link_up_exit_n_o <= 1'b1;
        end else begin
            hot_rst_exit_n_o <= ~hot_exit;
            link_up_exit_n_o <= ~link_lost;
        end
    end
endmodule

// File: verification/prs_checker.sv
// Purpose: port checker for the reset sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every prs_core_reset
`timescale 1ns/10ps
module prs_checker (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic por_n_i,
    input wire logic slot_rst_n_i,
    input wire logic core_ready_i,
    input wire logic pll_lock_raw_i,
    input wire logic hot_reset_i,
    input wire logic link_up_i,
    input wire logic pipe_sim_i,
    input wire logic fast_init_i,
    input wire logic clk_inuse_o,
    input wire logic reset_status_o,
    input wire logic pll_locked_o,
    input wire logic fast_init_o,
    input wire logic datapath_rst_o,
    input wire logic hot_rst_exit_n_o,
    input wire logic link_up_exit_n_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // hot reset state entered, then left
    sequence s_hot_exit;
        hot_reset_i ##1 !hot_reset_i;
    endsequence
    a_inuse_needs_ready: assert property ($rose(clk_inuse_o) |-> $past(core_ready_i))
        else $error("in use without ready");
    a_por_sets_status: assert property ($fell(por_n_i) |-> ##[1:4] reset_status_o)
        else $error("status missed power-on reset");
    a_status_after_por: assert property ($fell(reset_status_o) |-> $past(por_n_i, 3))
        else $error("status cleared under power-on reset");
    a_pll_follows_raw: assert property ((pll_lock_raw_i && !pipe_sim_i)[*4] |-> pll_locked_o)
        else $error("lock not passed on");
    a_pll_pipe_mode: assert property (pipe_sim_i[*3] |-> pll_locked_o)
        else $error("lock low in pipe mode");
    a_fast_init_flag: assert property (fast_init_i[*3] |-> fast_init_o)
        else $error("fast init flag low");
    a_slot_dp_reset: assert property ((!slot_rst_n_i)[*4] |-> datapath_rst_o)
        else $error("datapath not reset");
    a_hot_exit_pulse: assert property (
        s_hot_exit |-> ##[1:8] !hot_rst_exit_n_o ##1 hot_rst_exit_n_o)
        else $error("hot reset exit pulse wrong");
    a_pll_low_passed: assert property ((!pll_lock_raw_i && !pipe_sim_i)[*4] |-> !pll_locked_o)
        else $error("lock shown while unlocked");
    a_link_loss_reset: assert property ($fell(link_up_i) |-> ##[1:6] reset_status_o)
        else $error("status missed link loss");
endmodule
bind prs_core_reset prs_checker u_prs_checker (.*);

// File: verification/prs_app_model.sv
// Purpose: application logic model facing the sequencer
// Assumes: same fabric clock as the sequencer
// Notes:   ready follows lock, as when the core clock feeds the fabric
`timescale 1ns/10ps
module prs_app_model (
    input  wire logic core_clk_i,    // fabric clock
    input  wire logic run_en_i,      // bench lets the application run
    input  wire logic lock_i,        // pll lock from the core
    input  wire logic status_i,      // reset indication from the core
    input  wire logic inuse_i,       // clock in use from the core
    input  wire logic hot_exit_n_i,  // hot reset exit pulse
    input  wire logic link_exit_n_i, // link loss pulse
    output logic      core_ready_o,  // application ready
    output logic      app_rst_o      // application internal reset
);
    logic [5:0] hold_q = 6'h00;      // reset stretch after an exit pulse
    // ready only with a locked, stable clock
    assign core_ready_o = run_en_i & lock_i;
    // stretch own reset for 32 cycles after either exit pulse
    always_ff @(posedge core_clk_i) begin
        if (!hot_exit_n_i || !link_exit_n_i) begin
            hold_q <= 6'h20;
        end else if (hold_q != 6'h00) begin
            hold_q <= hold_q - 6'h01;
        end
    end
    // own reset from the core indication, held until clock in use
    assign app_rst_o = status_i | ~inuse_i | (|hold_q);
endmodule

// File: verification/tb_pcie_core_reset_status_handshake.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: 100 MHz fabric clock, application model as far side
// Notes:   one task per scenario; every wait is bounded
`timescale 1ns/10ps
module tb_pcie_core_reset_status_handshake;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic por_n = 1'b0, slot_n = 1'b0, pll = 1'b0, hot = 1'b0;
    logic link = 1'b1, pipe = 1'b0, fast = 1'b0, run = 1'b0;
    logic rdy, inuse, status, locked, fast_o, dp_rst, hot_n, link_n, app_rst;
    int   err_total = 0;
    int   n_compared = 0;
    always #5 clk = ~clk;
    prs_core_reset uut (
        .core_clk_i(clk), .sys_rst_i(rst), .por_n_i(por_n), .slot_rst_n_i(slot_n),
        .core_ready_i(rdy), .pll_lock_raw_i(pll), .hot_reset_i(hot), .link_up_i(link),
        .pipe_sim_i(pipe), .fast_init_i(fast), .clk_inuse_o(inuse),
        .reset_status_o(status), .pll_locked_o(locked), .fast_init_o(fast_o),
        .datapath_rst_o(dp_rst), .hot_rst_exit_n_o(hot_n), .link_up_exit_n_o(link_n));
    prs_app_model u_app (
        .core_clk_i(clk), .run_en_i(run), .lock_i(locked), .status_i(status),
        .inuse_i(inuse), .hot_exit_n_i(hot_n), .link_exit_n_i(link_n),
        .core_ready_o(rdy), .app_rst_o(app_rst));
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // bounded wait for a level, then judged
    task automatic wait_v(ref logic s, input logic v, input string m);
        int i;
        #1;
        for (i = 0; i < 100 && s !== v; i++) begin
            @(posedge clk);
            #1;
        end
        chk(s, v, m);
        if (s !== v) test_done();
    endtask
    task automatic t_power_up;
        repeat (5) @(posedge clk);
        #1;
        chk(status, 1'b1, "status low in power-on reset");
        @(posedge clk) {por_n, slot_n, pll, run} <= 4'hf;
        repeat (10) @(posedge clk);
        #1;
        chk(status, 1'b1, "status cleared too soon");
        wait_v(status, 1'b0, "status never cleared");
        wait_v(inuse, 1'b1, "clock never in use");
    endtask
    task automatic t_ready_pll;
        @(posedge clk) run <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(inuse, 1'b0, "in use without ready");
        @(posedge clk) {run, pll} <= 2'b10;
        repeat (5) @(posedge clk);
        #1;
        chk(locked, 1'b0, "lock shown while unlocked");
        chk(inuse, 1'b0, "in use kept without lock");
        @(posedge clk) pipe <= 1'b1;
        wait_v(locked, 1'b1, "pipe mode lock low");
        @(posedge clk) {pipe, pll} <= 2'b01;
        wait_v(inuse, 1'b1, "no return to in use");
    endtask
    task automatic t_fast_slot;
        @(posedge clk) {fast, slot_n} <= 2'b10;
        repeat (5) @(posedge clk);
        #1;
        chk(fast_o, 1'b1, "fast init flag low");
        chk(dp_rst, 1'b1, "datapath not reset");
        @(posedge clk) {fast, slot_n} <= 2'b01;
        wait_v(dp_rst, 1'b0, "datapath reset stuck");
        chk(fast_o, 1'b0, "fast init flag stuck");
    endtask
    task automatic t_hot_link;
        @(posedge clk) hot <= 1'b1;
        wait_v(status, 1'b1, "no reset on hot reset");
        @(posedge clk) hot <= 1'b0;
        wait_v(hot_n, 1'b0, "no hot reset exit pulse");
        @(posedge clk);
        #1;
        chk(hot_n, 1'b1, "exit pulse too long");
        wait_v(inuse, 1'b1, "no recovery after hot reset");
        @(posedge clk) link <= 1'b0;
        wait_v(link_n, 1'b0, "no link loss pulse");
        wait_v(status, 1'b1, "no reset on link loss");
        @(posedge clk) link <= 1'b1;
        wait_v(inuse, 1'b1, "no recovery after link loss");
    endtask
    // power-on reset pulled low in mid-run, then released again
    task automatic t_por_mid;
        @(posedge clk) por_n <= 1'b0;
        wait_v(status, 1'b1, "no reset on power-on reset");
        chk(dp_rst, 1'b1, "datapath not reset by power-on");
        wait_v(inuse, 1'b0, "in use kept under power-on reset");
        @(posedge clk) por_n <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk(status, 1'b1, "status cleared before hold ended");
        wait_v(status, 1'b0, "status stuck after power-on");
        chk(dp_rst, 1'b0, "datapath reset stuck after power-on");
        wait_v(inuse, 1'b1, "no recovery after power-on");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_power_up();
        t_ready_pll();
        t_fast_slot();
        t_hot_link();
        t_por_mid();
        test_done();
    end
endmodule
